//--- core/stm_pkg.sv
// package of constants for the standard timer mode logic
// assumes a single clock domain; counting advanced by a timer-clock enable
package stm_pkg;
  localparam int CounterWidth = 16;
  localparam int PeriodWidth = 8;
  localparam logic [1:0] ModeCompare = 2'h0;
  localparam logic [1:0] ModeCapture = 2'h1;
  localparam logic [1:0] ModePwm = 2'h2;
  localparam logic [1:0] ModeTimer = 2'h3;
  localparam logic [1:0] ActNoChange = 2'h0;
  localparam logic [1:0] ActLow = 2'h1;
  localparam logic [1:0] ActHigh = 2'h2;
  localparam logic [1:0] ActToggle = 2'h3;
  localparam logic [1:0] PwmInactive = 2'h0;
  localparam logic [1:0] PwmActive = 2'h1;
  localparam logic [1:0] PwmWave = 2'h2;
  localparam logic [1:0] PwmSingle = 2'h3;
  localparam logic [15:0] CounterReset = 16'h0000;
  localparam logic OutReset = 1'b0;
endpackage

//--- core/stm_edge_detect.sv
// rising-edge detector on a synchronous level
// assumes the input is already synchronous to clk
`timescale 1ns/1ps
module stm_edge_detect (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // level in, pulse out
  input wire logic level,
  output logic rise
);
  logic level_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level;
    end
  end

  assign rise = level & ~level_q;
endmodule

//--- core/stm_timer.sv
// operating-mode logic of a 16-bit standard timer
// assumes control fields are synchronous levels and timerTick is a one-cycle enable
`timescale 1ns/1ps

//
// Operation
// - mode 00 is compare-match output, mode 11 is plain timer/counter.
// - clear-select low clears on P match, or overflow when P value zero.
// - clear-select low raises both A and P match flags.
// - clear-select high clears on A match, only A flag raised.
// - compare-match pin changes on A match or run rise, never on P match.
// - A match drives pin high, low, toggles, or leaves it per action.
// - compare actions: 00 none, 01 low, 10 high, 11 toggle.
// - rising run bit loads pin with the initial level.
// - timer/counter mode counts like compare mode, pin left undriven.
// - PWM period register clears counter; swap bit picks which register.
// - P value counts in 256 clocks; zero means 65536 clocks.
// - duty at or above period holds output active all period.
// - PWM raises A flag on A match and P flag on P match.
// - PWM counting continues while the pin is forced fixed.
// - PWM actions: 00 inactive, 01 active, 10 PWM, 11 single pulse.
// - initial level picks PWM polarity, invert flips pin, clear-select ignored.
// - invert bit reverses the waveform level on the pin.
// - trigger pin edge sets run; rising run starts counter and pulse.
// - A match clears run ending pulse with flag; software clear ends it.
// - single pulse counter zeroes only on run rise; P, clear, swap ignored.
// - counter is 16 bits; 8-bit P value meets its upper byte.
// - P matches fall at multiples of 256 timer clocks.
module stm_timer #(
  parameter int CounterBits = stm_pkg::CounterWidth,
  parameter int PeriodBits = stm_pkg::PeriodWidth
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // timer clock enable
  input wire logic timerTick,
  // control fields
  input wire logic [1:0] modeSelect,
  input wire logic [1:0] outputActionSelect,
  input wire logic outputInitialLevel,
  input wire logic outputInvert,
  input wire logic periodDutySwap,
  input wire logic counterClearSelect,
  input wire logic runWrite,
  input wire logic runWriteValue,
  // compare values
  input wire logic [CounterBits-1:0] compareAValue,
  input wire logic [PeriodBits-1:0] comparePValue,
  // external trigger, one-cycle active-edge level already synchronous
  input wire logic externalTriggerPin,
  // flag clears from software
  input wire logic matchAFlagClear,
  input wire logic matchPFlagClear,
  // status
  output logic counterRun,
  output logic [CounterBits-1:0] counterValue,
  output logic matchAFlag,
  output logic matchPFlag,
  // output pin
  output logic timerOutputPin,
  output logic timerOutputEnable
);

  initial begin
    if (CounterBits != 16 || PeriodBits != 8) begin
      $error("stm_timer supports only a 16-bit counter with an 8-bit P value");
    end
  end

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  logic isCompare;
  logic isTimer;
  logic isPwmMode;
  logic isSingle;
  logic isPwm;

  assign isCompare = (modeSelect == stm_pkg::ModeCompare);
  assign isTimer = (modeSelect == stm_pkg::ModeTimer);
  assign isPwmMode = (modeSelect == stm_pkg::ModePwm);
  // single pulse is taken from the action field, which software must hold
  assign isSingle = isPwmMode && (outputActionSelect == stm_pkg::PwmSingle);
  assign isPwm = isPwmMode && !isSingle;

  // ------------------------------------------------------------
  // run bit
  // ------------------------------------------------------------
  logic run_q;
  logic run_d;
  logic runRise;
  logic matchA;
  logic matchP;
  logic tick;

  stm_edge_detect runEdge (
    .clk(clk),
    .srst(srst),
    .level(run_d),
    .rise(runRise)
  );

  always_comb begin
    run_d = run_q;
    if (runWrite) begin
      run_d = runWriteValue;
    end
    if (isSingle && externalTriggerPin) begin
      run_d = 1'b1;
    end
    // hardware clear wins last so the pulse width is bounded by the A value
    if (isSingle && tick && matchA) begin
      run_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      run_q <= 1'b0;
    end else begin
      run_q <= run_d;
    end
  end

  // ------------------------------------------------------------
  // comparators
  // ------------------------------------------------------------
  logic [CounterBits-1:0] count_q;
  logic [CounterBits-1:0] countNext;
  logic overflow;
  logic pZero;

  assign tick = timerTick && run_q;
  assign countNext = count_q + 16'h0001;
  assign overflow = (count_q == 16'hFFFF);
  assign pZero = (comparePValue == 8'h00);
  // match is taken on the count that is about to be reached
  assign matchA = (countNext == compareAValue);
  // P compares the upper byte and needs the low byte zero, so matches fall on 256 boundaries
  assign matchP = pZero ? overflow
                : (countNext[15:8] == comparePValue && countNext[7:0] == 8'h00);

  // ------------------------------------------------------------
  // counter clear selection
  // ------------------------------------------------------------
  logic clearNow;
  logic periodMatch;
  logic dutyMatch;

  // PWM period register chosen by the swap bit; clear-select ignored here
  assign periodMatch = periodDutySwap ? matchA : matchP;
  assign dutyMatch = periodDutySwap ? matchP : matchA;

  always_comb begin
    clearNow = 1'b0;
    if (isPwm) begin
      clearNow = periodMatch;
    end else if (isSingle) begin
      clearNow = 1'b0;
    end else if (counterClearSelect) begin
      clearNow = matchA;
    end else begin
      clearNow = matchP;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count_q <= stm_pkg::CounterReset;
    end else if (runRise) begin
      count_q <= stm_pkg::CounterReset;
    end else if (tick) begin
      if (clearNow) begin
        count_q <= stm_pkg::CounterReset;
      end else begin
        count_q <= countNext;
      end
    end
  end

  // ------------------------------------------------------------
  // match flags, set wins over clear
  // ------------------------------------------------------------
  logic setA;
  logic setP;

  assign setA = tick && matchA;
  // P flag suppressed when A clears the counter outside PWM; unused in single pulse
  assign setP = tick && matchP && !isSingle
              && (isPwm || !counterClearSelect);

  always_ff @(posedge clk) begin
    if (srst) begin
      matchAFlag <= 1'b0;
    end else if (setA) begin
      matchAFlag <= 1'b1;
    end else if (matchAFlagClear) begin
      matchAFlag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      matchPFlag <= 1'b0;
    end else if (setP) begin
      matchPFlag <= 1'b1;
    end else if (matchPFlagClear) begin
      matchPFlag <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // compare-match output level
  // ------------------------------------------------------------
  logic cmpLevel_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      cmpLevel_q <= stm_pkg::OutReset;
    end else if (runRise) begin
      cmpLevel_q <= outputInitialLevel;
    end else if (isCompare && setA) begin
      case (outputActionSelect)
        stm_pkg::ActLow: cmpLevel_q <= 1'b0;
        stm_pkg::ActHigh: cmpLevel_q <= 1'b1;
        stm_pkg::ActToggle: cmpLevel_q <= ~cmpLevel_q;
        default: cmpLevel_q <= cmpLevel_q;
      endcase
    end
  end

  // ------------------------------------------------------------
  // PWM / single pulse active state
  // ------------------------------------------------------------
  logic pwmActive_q;
  logic dutyFull;
  logic [16:0] periodLen;
  logic [16:0] dutyLen;

  // lengths in timer clocks; P zero stands for the full 65536 count
  assign periodLen = periodDutySwap ? {1'b0, compareAValue}
                   : (pZero ? 17'h10000 : {1'b0, comparePValue, 8'h00});
  assign dutyLen = periodDutySwap
                 ? (pZero ? 17'h10000 : {1'b0, comparePValue, 8'h00})
                 : {1'b0, compareAValue};
  assign dutyFull = (dutyLen >= periodLen);

  // state runs in actions 00, 01 and 10, so forcing the pin loses no phase
  always_ff @(posedge clk) begin
    if (srst) begin
      pwmActive_q <= 1'b0;
    end else if (isSingle) begin
      pwmActive_q <= run_d;
    end else if (!isPwm) begin
      pwmActive_q <= 1'b0;
    end else if (runRise) begin
      pwmActive_q <= 1'b1;
    end else if (tick) begin
      if (periodMatch || dutyFull) begin
        pwmActive_q <= 1'b1;
      end else if (dutyMatch) begin
        pwmActive_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------
  logic waveActive;
  logic waveLevel;
  logic pinLevel_d;

  always_comb begin
    case (outputActionSelect)
      stm_pkg::PwmInactive: waveActive = 1'b0;
      stm_pkg::PwmActive: waveActive = 1'b1;
      default: waveActive = pwmActive_q;
    endcase
    // initial level sets active-high or active-low
    waveLevel = outputInitialLevel ? waveActive : ~waveActive;
    pinLevel_d = isCompare ? cmpLevel_q : waveLevel;
    pinLevel_d = pinLevel_d ^ outputInvert;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      timerOutputPin <= stm_pkg::OutReset;
      timerOutputEnable <= 1'b0;
    end else begin
      timerOutputPin <= pinLevel_d;
      // capture and timer modes release the pin for other use
      timerOutputEnable <= isCompare || isPwmMode;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      counterRun <= 1'b0;
      counterValue <= stm_pkg::CounterReset;
    end else begin
      counterRun <= run_d;
      counterValue <= count_q;
    end
  end

endmodule

//--- verification/stm_timer_checker.sv
// concurrent checks on the timer mode logic ports
// assumes binding to stm_timer, one clock, srst synchronous
`timescale 1ns/1ps
module stm_timer_checker #(
  parameter int CounterBits = 16,
  parameter int PeriodBits = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control fields
  input wire logic [1:0] modeSelect,
  input wire logic [1:0] outputActionSelect,
  input wire logic outputInitialLevel,
  input wire logic outputInvert,
  input wire logic counterClearSelect,
  input wire logic matchAFlagClear,
  input wire logic [CounterBits-1:0] compareAValue,
  // status and pin
  input wire logic counterRun,
  input wire logic [CounterBits-1:0] counterValue,
  input wire logic matchAFlag,
  input wire logic matchPFlag,
  input wire logic timerOutputPin,
  input wire logic timerOutputEnable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_timer_pin_off: assert property ((modeSelect == stm_pkg::ModeTimer)[*3] |->
    !timerOutputEnable) else $error("pin driven in timer mode");
  a_compare_pin_on: assert property ((modeSelect == stm_pkg::ModeCompare)[*3] |->
    timerOutputEnable) else $error("pin not driven in compare mode");
  a_p_flag_gate: assert property ($rose(matchPFlag) |->
    $past(!counterClearSelect || modeSelect == stm_pkg::ModePwm)) else $error("p flag raised");
  a_count_below_a: assert property (counterRun && counterClearSelect &&
    modeSelect == stm_pkg::ModeCompare |-> counterValue <= compareAValue)
    else $error("counter passed compare a");
  a_flag_stays_set: assert property (matchAFlag && !matchAFlagClear |=> matchAFlag)
    else $error("a flag dropped");
  a_pulse_ends_run: assert property ($rose(matchAFlag) && modeSelect == stm_pkg::ModePwm &&
    outputActionSelect == stm_pkg::PwmSingle |-> ##[0:2] !counterRun) else $error("run kept");
  // counterValue lags the internal count by one cycle, so look one cycle on
  a_run_from_zero: assert property ($rose(counterRun) |-> ##1 counterValue <= 16'h0002)
    else $error("counter not restarted");
  a_forced_active: assert property ((modeSelect == stm_pkg::ModePwm &&
    outputActionSelect == stm_pkg::PwmActive && $stable(outputInitialLevel) &&
    $stable(outputInvert))[*3] |-> timerOutputPin == (outputInitialLevel ^ outputInvert))
    else $error("forced level wrong");
  a_match_drives_high: assert property ($rose(matchAFlag) &&
    modeSelect == stm_pkg::ModeCompare && outputActionSelect == stm_pkg::ActHigh |->
    ##[0:2] timerOutputPin) else $error("pin not high after match");
  c_p_match: cover property ($rose(matchPFlag));
  c_run_end: cover property ($fell(counterRun));
  c_pwm_active: cover property (timerOutputPin && modeSelect == stm_pkg::ModePwm);
endmodule
bind stm_timer stm_timer_checker #(.CounterBits(CounterBits), .PeriodBits(PeriodBits)) u_chk (
  .clk, .srst, .modeSelect, .outputActionSelect, .outputInitialLevel, .outputInvert,
  .counterClearSelect, .matchAFlagClear, .compareAValue, .counterRun, .counterValue,
  .matchAFlag, .matchPFlag, .timerOutputPin, .timerOutputEnable);

//--- verification/test_stm_timer.sv
// self-checking bench for the timer mode logic
// assumes stm_timer and stm_pkg compiled first; inputs change on falling edges
`timescale 1ns/1ps
module test_stm_timer;
  typedef struct {logic [1:0] mode; logic [1:0] act; logic init; logic pin; logic en;} row_t;
  logic clk = 0, srst = 1, tick = 0, oInit = 0, oInv = 0, swap = 0, cclr = 1;
  logic runWr = 0, runVal = 0, trig = 0, clrA = 0, clrP = 0;
  logic [1:0] mode = 2'h0, act = 2'h0;
  logic [15:0] aVal = 16'h0180; // never zero in compare mode
  logic [7:0] pVal = 8'h01;
  logic run, aFlag, pFlag, pin, en;
  logic [15:0] cnt;
  int n_errors = 0, num_checks = 0, cycles = 0, hiCnt;
  row_t rows [6] = '{'{2'h0, 2'h0, 1, 1, 1}, '{2'h0, 2'h1, 1, 0, 1}, '{2'h0, 2'h2, 0, 1, 1},
    '{2'h0, 2'h3, 0, 1, 1}, '{2'h0, 2'h3, 1, 0, 1}, '{2'h3, 2'h2, 0, 0, 0}};
  stm_timer u_stm_timer (.clk(clk), .srst(srst), .timerTick(tick), .modeSelect(mode),
    .outputActionSelect(act), .outputInitialLevel(oInit), .outputInvert(oInv),
    .periodDutySwap(swap), .counterClearSelect(cclr), .runWrite(runWr),
    .runWriteValue(runVal), .compareAValue(aVal), .comparePValue(pVal),
    .externalTriggerPin(trig), .matchAFlagClear(clrA), .matchPFlagClear(clrP),
    .counterRun(run), .counterValue(cnt), .matchAFlag(aFlag), .matchPFlag(pFlag),
    .timerOutputPin(pin), .timerOutputEnable(en));
  initial forever #4 clk = ~clk;
  // hang guard well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      close_out;
    end
  end
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic setRun(logic v);
    @(negedge clk);
    runWr = 1;
    runVal = v;
    cyc(1);
    runWr = 0;
  endtask
  task automatic clearFlags;
    clrA = 1;
    clrP = 1;
    cyc(1);
    clrA = 0;
    clrP = 0;
  endtask
  // selP picks the p flag, otherwise the a flag
  task automatic waitFlag(logic selP);
    int i;
    for (i = 0; i < 1000 && (selP ? pFlag : aFlag) !== 1'b1; i++) cyc(1);
  endtask
  task automatic highFor(int n);
    hiCnt = 0;
    repeat (n) begin
      cyc(1);
      hiCnt += (pin === 1'b1);
    end
  endtask
  // restart with a new pwm setup, then measure two whole periods
  task automatic pwm(logic [1:0] a, logic inv, logic sw, logic [15:0] av, logic [7:0] pv);
    setRun(0);
    act = a;
    oInv = inv;
    swap = sw;
    aVal = av;
    pVal = pv;
    clearFlags;
    setRun(1);
    cyc(300);
    highFor(512);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    cyc(6);
    srst = 0;
    cyc(1);
    check("pin at reset", pin, 0);
    check("flags at reset", {aFlag, pFlag, run}, 0);
    foreach (rows[i]) begin
      setRun(0);
      tick = 0;
      {mode, act, oInit} = {rows[i].mode, rows[i].act, rows[i].init};
      clearFlags;
      tick = 1;
      setRun(1);
      cyc(2);
      check("run", run, 1);
      check("enable", en, rows[i].en);
      if (rows[i].en) check("initial pin", pin, rows[i].init);
      waitFlag(1'b0);
      tick = 0;
      check("a flag", aFlag, 1);
      check("p flag unset", pFlag, 0);
      cyc(3);
      if (rows[i].en) check("pin after match", pin, rows[i].pin);
    end
    // clear on p: both flags, counter wraps at 256
    setRun(0);
    {mode, act, cclr, aVal} = {2'h0, 2'h0, 1'b0, 16'h0010};
    clearFlags;
    tick = 1;
    setRun(1);
    waitFlag(1'b1);
    check("a flag on p clear", aFlag, 1);
    cyc(4);
    check("wrapped", cnt < 16'h0100, 1);
    mode = 2'h2;
    oInit = 1;
    pwm(2'h2, 0, 0, 16'h0040, 8'h01);
    check("pwm duty", hiCnt, 128);
    pwm(2'h2, 1, 0, 16'h0040, 8'h01);
    check("pwm inverted", hiCnt, 384);
    pwm(2'h2, 0, 1, 16'h0100, 8'h00);
    check("full duty", hiCnt, 512);
    pwm(2'h0, 0, 0, 16'h0040, 8'h01);
    check("forced off", hiCnt, 0);
    check("counting on", pFlag, 1);
    pwm(2'h1, 0, 0, 16'h0040, 8'h01);
    check("forced on", hiCnt, 512);
    // single pulse from the trigger pin, width set by compare a
    setRun(0);
    act = 2'h3;
    aVal = 16'h0014;
    clearFlags;
    trig = 1;
    cyc(1);
    trig = 0;
    highFor(60);
    check("pulse width", hiCnt >= 19 && hiCnt <= 21, 1);
    check("run cleared", run, 0);
    check("pulse flag", aFlag, 1);
    close_out;
  end
endmodule
